// file: slem_chk_checker.sv
/* Port checker for the second-level event aggregator.
   Assumes it is bound to slem_second_level_aggregator. */
`timescale 1ns/1ns
module slem_chk (
  // Clock and reset
  input wire         i_clock,
  input wire         i_rst,
  // Sources and requests
  input wire [255:0] i_event_pulse,
  input wire         i_debug_request,
  input wire [3:0]   i_ext_pin_request,
  input wire         i_mac_receive_top_request,
  input wire         i_mac_transmit_top_request,
  input wire         i_security_top_request,
  input wire [19:0]  o_top_request,
  // Bus handshakes
  input wire         o_awready,
  input wire         o_wready,
  input wire         o_bvalid,
  input wire         i_bready,
  input wire [1:0]   o_bresp,
  input wire         i_arvalid,
  input wire         o_arready,
  input wire         o_rvalid,
  input wire         i_rready,
  input wire [31:0]  o_rdata
);
  // Second-level request bits
  localparam [19:0] SL = 20'he0863;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  direct_map_a: assert property ({o_top_request[16:12], o_top_request[10:9], o_top_request[7]} ==
    {i_debug_request, i_ext_pin_request, i_mac_receive_top_request, i_mac_transmit_top_request,
     i_security_top_request}) else $error("direct request map wrong");
  spare_zero_a: assert property (o_top_request[4:2] == 3'h0 && !o_top_request[8])
    else $error("spare request bit set");
  fall_by_write_a: assert property (|($past(o_top_request) & SL & ~o_top_request) |-> $rose(o_bvalid))
    else $error("request dropped without write");
  rise_cause_a: assert property (|(o_top_request & SL & ~$past(o_top_request)) |->
    (|$past(i_event_pulse)) || $rose(o_bvalid)) else $error("request rose without cause");
  b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  b_drop_a: assert property (o_bvalid && i_bready |=> !o_bvalid) else $error("write response stuck");
  w_busy_a: assert property (o_bvalid |-> !o_awready && !o_wready) else $error("write taken while busy");
  r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  r_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("read answer late");
endmodule
bind slem_second_level_aggregator slem_chk u_chk (.i_clock, .i_rst, .i_event_pulse, .i_debug_request,
  .i_ext_pin_request, .i_mac_receive_top_request, .i_mac_transmit_top_request, .i_security_top_request,
  .o_top_request, .o_awready, .o_wready, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
  .o_rvalid, .i_rready, .o_rdata);

// file: slem_defines.vh
/*
 * Register map, flag layouts and reset values of the second-level event aggregator.
 * Assumes one 32-bit AXI4-Lite slave; offsets are byte addresses of aligned words.
 */
`ifndef SLEM_DEFINES_VH
`define SLEM_DEFINES_VH

// Peripheral count and indices
`define SLEM_NPER        8
`define SLEM_P_TMR1      0
`define SLEM_P_TMR2      1
`define SLEM_P_SC1       2
`define SLEM_P_SC2       3
`define SLEM_P_ADC       4
`define SLEM_P_SC3       5
`define SLEM_P_SC4       6
`define SLEM_P_USB       7

// Register offsets: flags at 0x00 + 4*p, masks at 0x40 + 4*p
`define SLEM_OFS_FLAG    8'h00
`define SLEM_OFS_MASK    8'h40
`define SLEM_OFS_MISS    8'h80
`define SLEM_OFS_TOPLVL  8'h84
`define SLEM_ADDR_W      8

// Implemented flag bits per peripheral
`define SLEM_IMPL_TMR1   32'h0000005f
`define SLEM_IMPL_TMR2   32'h0000005f
`define SLEM_IMPL_SC1    32'h00007fff
`define SLEM_IMPL_SC2    32'h00001fff
`define SLEM_IMPL_ADC    32'h0000001f
`define SLEM_IMPL_SC3    32'h00007fff
`define SLEM_IMPL_SC4    32'h00001fff
`define SLEM_IMPL_USB    32'h00ffffff

// Top-level bit positions
`define SLEM_TOP_TMR1    0
`define SLEM_TOP_TMR2    1
`define SLEM_TOP_SC1     5
`define SLEM_TOP_SC2     6
`define SLEM_TOP_SEC     7
`define SLEM_TOP_MACTX   9
`define SLEM_TOP_MACRX   10
`define SLEM_TOP_ADC     11
`define SLEM_TOP_PIN_A   12
`define SLEM_TOP_DEBUG   16
`define SLEM_TOP_SC3     17
`define SLEM_TOP_SC4     18
`define SLEM_TOP_USB     19
`define SLEM_TOP_W       20

// Reset values
`define SLEM_RST_REG     32'h00000000

// AXI responses
`define SLEM_RESP_OKAY   2'h0
`define SLEM_RESP_SLVERR 2'h2

`endif

// file: slem_evsrc.sv
/* Peripheral event source model.
   Assumes bench requests arrive by non-blocking assignment at rising edges. */
`timescale 1ns/1ns
module slem_evsrc (
  // Control from bench
  input  wire         i_clock,
  input  wire         i_go,
  input  wire [7:0]   i_idx,
  // Event pulses
  output reg  [255:0] o_pulse
);
  initial o_pulse = 256'h0;
  // One pulse cycle per requested cycle
  always @(posedge i_clock) begin
    o_pulse <= i_go ? (256'h1 << i_idx) : 256'h0;
  end
endmodule

// file: slem_second_level_aggregator.v
/*
 * Second-level event aggregator: per-peripheral sticky flags, enable masks,
 * OR into level requests for the top-level controller, and missed-event bits.
 * Assumes event inputs are synchronous one-cycle pulses and an AXI4-Lite master.
 * Unmapped or unaligned accesses answer SLVERR and change nothing.
 * The protection inputs of both address channels are not checked.
 */
// Decided for this implementation: register access over AXI4-Lite and the address map.
//
// Contract
// - OR enabled flags into one request
// - Mask write 1 enables, 0 disables
// - Mask gates each flag bit individually
// - Flag write 1 clears, 0 no effect
// - Events set flags regardless of mask
// - Late mask set forwards pending flag
// - Request is level while enabled flag set
// - Top request holds until flags or mask bits cleared
// - Set wins over simultaneous clear
// - No counting or queuing of events
// - Enabled repeat sets peripheral missed bit
// - One missed bit per top interrupt
// - Missed bits write 1 to clear
// - Direct sources drive top bits directly
// - Top requests are levels, enable-gated upstream
`timescale 1ns/1ns
`include "slem_defines.vh"

module slem_second_level_aggregator #(
  parameter NPER = `SLEM_NPER
) (
  // Clock and reset
  input  wire                      i_clock,
  input  wire                      i_rst,
  // Event pulses, 32 per peripheral, peripheral p at [32*p +: 32]
  input  wire [32*`SLEM_NPER-1:0]  i_event_pulse,
  // Direct top-level sources
  input  wire                      i_debug_request,
  input  wire [3:0]                i_ext_pin_request,
  input  wire                      i_mac_receive_top_request,
  input  wire                      i_mac_transmit_top_request,
  input  wire                      i_security_top_request,
  // Requests to the top-level interrupt controller
  output wire [`SLEM_TOP_W-1:0]    o_top_request,
  // AXI4-Lite write address
  input  wire                      i_awvalid,
  output wire                      o_awready,
  input  wire [`SLEM_ADDR_W-1:0]   i_awaddr,
  input  wire [2:0]                i_awprot,
  // AXI4-Lite write data
  input  wire                      i_wvalid,
  output wire                      o_wready,
  input  wire [31:0]               i_wdata,
  input  wire [3:0]                i_wstrb,
  // AXI4-Lite write response
  output wire                      o_bvalid,
  input  wire                      i_bready,
  output wire [1:0]                o_bresp,
  // AXI4-Lite read address
  input  wire                      i_arvalid,
  output wire                      o_arready,
  input  wire [`SLEM_ADDR_W-1:0]   i_araddr,
  input  wire [2:0]                i_arprot,
  // AXI4-Lite read data
  output wire                      o_rvalid,
  input  wire                      i_rready,
  output wire [31:0]               o_rdata,
  output wire [1:0]                o_rresp
);

  // Assigned flag bits of peripheral p
  function [31:0] impl_bits;
    input integer per;
    begin
      case (per)
        `SLEM_P_TMR1: impl_bits = `SLEM_IMPL_TMR1;
        `SLEM_P_TMR2: impl_bits = `SLEM_IMPL_TMR2;
        `SLEM_P_SC1:  impl_bits = `SLEM_IMPL_SC1;
        `SLEM_P_SC2:  impl_bits = `SLEM_IMPL_SC2;
        `SLEM_P_ADC:  impl_bits = `SLEM_IMPL_ADC;
        `SLEM_P_SC3:  impl_bits = `SLEM_IMPL_SC3;
        `SLEM_P_SC4:  impl_bits = `SLEM_IMPL_SC4;
        `SLEM_P_USB:  impl_bits = `SLEM_IMPL_USB;
        default:      impl_bits = 32'h00000000;
      endcase
    end
  endfunction

  // Top-level bit fed by peripheral per
  function [4:0] top_bit;
    input integer per;
    integer       pos;
    begin
      case (per)
        `SLEM_P_TMR1: pos = `SLEM_TOP_TMR1;
        `SLEM_P_TMR2: pos = `SLEM_TOP_TMR2;
        `SLEM_P_SC1:  pos = `SLEM_TOP_SC1;
        `SLEM_P_SC2:  pos = `SLEM_TOP_SC2;
        `SLEM_P_ADC:  pos = `SLEM_TOP_ADC;
        `SLEM_P_SC3:  pos = `SLEM_TOP_SC3;
        `SLEM_P_SC4:  pos = `SLEM_TOP_SC4;
        `SLEM_P_USB:  pos = `SLEM_TOP_USB;
        default:      pos = 0;
      endcase
      top_bit = pos[4:0];
    end
  endfunction

  // Byte lane expansion of write strobes
  function [31:0] lane_mask;
    input [3:0] strb;
    begin
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // Event pulses of peripheral per
  function [31:0] events_of;
    input [32*`SLEM_NPER-1:0] vec;
    input integer             per;
    begin
      events_of = vec[32*per +: 32];
    end
  endfunction

  // Write channel states, one-hot
  localparam [2:0] WS_IDLE = 3'h1;
  localparam [2:0] WS_RESP = 3'h2;
  localparam [2:0] WS_DONE = 3'h4;

  // Register regions, one-hot
  localparam [4:0] RG_FLAG = 5'h01;
  localparam [4:0] RG_MASK = 5'h02;
  localparam [4:0] RG_MISS = 5'h04;
  localparam [4:0] RG_TOP  = 5'h08;
  localparam [4:0] RG_NONE = 5'h10;

  // Region holding a word address; unaligned and unmapped give none
  function [4:0] region;
    input [`SLEM_ADDR_W-1:0] addr;
    begin
      if (addr[1:0] != 2'h0) begin
        region = RG_NONE;
      end else if (addr[7:5] == 3'h0) begin
        region = RG_FLAG;
      end else if (addr[7:5] == 3'h2) begin
        region = RG_MASK;
      end else if (addr == `SLEM_OFS_MISS) begin
        region = RG_MISS;
      end else if (addr == `SLEM_OFS_TOPLVL) begin
        region = RG_TOP;
      end else begin
        region = RG_NONE;
      end
    end
  endfunction

  reg  [31:0]             flag_ff [0:`SLEM_NPER-1];
  reg  [31:0]             mask_ff [0:`SLEM_NPER-1];
  reg  [31:0]             nxt_flag [0:`SLEM_NPER-1];
  reg  [31:0]             nxt_mask [0:`SLEM_NPER-1];
  reg  [`SLEM_TOP_W-1:0]  miss_ff;
  reg  [`SLEM_TOP_W-1:0]  nxt_miss;
  reg  [`SLEM_TOP_W-1:0]  top_req;

  reg  [2:0]              wstate_ff;
  reg                     aw_got_ff;
  reg                     w_got_ff;
  reg  [`SLEM_ADDR_W-1:0] awaddr_ff;
  reg  [31:0]             wdata_ff;
  reg  [3:0]              wstrb_ff;
  reg  [1:0]              bresp_ff;
  reg                     rvalid_ff;
  reg  [31:0]             rdata_ff;
  reg  [1:0]              rresp_ff;

  wire                    aw_take;
  wire                    w_take;
  wire                    wr_fire;
  wire [31:0]             wr_bits;
  wire                    wr_flag_hit;
  wire                    wr_mask_hit;
  wire [2:0]              wr_idx;
  wire                    wr_map_ok;
  wire [4:0]              wr_region;
  wire [4:0]              rd_region;
  wire [2:0]              rd_idx;
  wire [`SLEM_TOP_W-1:0]  miss_clr;
  reg  [31:0]             rd_val;
  reg                     rd_ok;
  integer                 mp;
  integer                 fp;
  integer                 sp;
  integer                 tp;
  integer                 rp;

  // Write channel: address and data taken in any order
  assign o_awready = wstate_ff[0] & ~aw_got_ff;
  assign o_wready  = wstate_ff[0] & ~w_got_ff;
  assign aw_take   = i_awvalid & o_awready;
  assign w_take    = i_wvalid & o_wready;
  assign wr_fire   = wstate_ff[0] & (aw_got_ff | aw_take) & (w_got_ff | w_take);
  assign o_bvalid  = wstate_ff[1];
  assign o_bresp   = bresp_ff;

  // Decode of the write being committed
  wire [`SLEM_ADDR_W-1:0] wa = aw_got_ff ? awaddr_ff : i_awaddr;
  wire [31:0]             wd = w_got_ff ? wdata_ff : i_wdata;
  wire [3:0]              ws = w_got_ff ? wstrb_ff : i_wstrb;
  assign wr_bits     = wd & lane_mask(ws);
  assign wr_idx      = wa[4:2];
  assign wr_region   = region(wa);
  assign rd_region   = region(i_araddr);
  assign rd_idx      = i_araddr[4:2];
  assign wr_flag_hit = wr_fire & (wr_region == RG_FLAG);
  assign wr_mask_hit = wr_fire & (wr_region == RG_MASK);
  assign wr_map_ok   = (wr_region != RG_NONE);
  // Missed-bit clear loses to a coincident set
  assign miss_clr    = (wr_fire && wr_region == RG_MISS) ? wr_bits[`SLEM_TOP_W-1:0] : {`SLEM_TOP_W{1'b0}};

  // Mask next state
  always @* begin
    for (mp = 0; mp < `SLEM_NPER; mp = mp + 1) begin
      nxt_mask[mp] = mask_ff[mp];
      if (wr_mask_hit && wr_idx == mp[2:0]) begin
        nxt_mask[mp] = (mask_ff[mp] & ~lane_mask(ws)) | wr_bits;
      end
    end
  end

  // Flag next state; events are ORed in after the clear
  always @* begin
    for (fp = 0; fp < `SLEM_NPER; fp = fp + 1) begin
      nxt_flag[fp] = flag_ff[fp];
      if (wr_flag_hit && wr_idx == fp[2:0]) begin
        nxt_flag[fp] = flag_ff[fp] & ~wr_bits;
      end
      nxt_flag[fp] = (nxt_flag[fp] | events_of(i_event_pulse, fp)) & impl_bits(fp);
    end
  end

  // Missed bits: clear first, then any new miss sets
  always @* begin
    nxt_miss = miss_ff & ~miss_clr;
    for (sp = 0; sp < `SLEM_NPER; sp = sp + 1) begin
      if (|(events_of(i_event_pulse, sp) & flag_ff[sp] & mask_ff[sp] & impl_bits(sp))) begin
        nxt_miss[top_bit(sp)] = 1'b1;
      end
    end
  end

  // Request levels to the top-level controller
  always @* begin
    top_req = {`SLEM_TOP_W{1'b0}};
    for (tp = 0; tp < `SLEM_NPER; tp = tp + 1) begin
      if (|(flag_ff[tp] & mask_ff[tp])) begin
        top_req[top_bit(tp)] = 1'b1;
      end
    end
    top_req[`SLEM_TOP_DEBUG]               = i_debug_request;
    top_req[`SLEM_TOP_PIN_A +: 4]          = i_ext_pin_request;
    top_req[`SLEM_TOP_MACRX]               = i_mac_receive_top_request;
    top_req[`SLEM_TOP_MACTX]               = i_mac_transmit_top_request;
    top_req[`SLEM_TOP_SEC]                 = i_security_top_request;
  end

  assign o_top_request = top_req;

  // Flag, mask and missed registers
  always @(posedge i_clock) begin
    if (i_rst) begin
      for (rp = 0; rp < `SLEM_NPER; rp = rp + 1) begin
        flag_ff[rp] <= `SLEM_RST_REG;
        mask_ff[rp] <= `SLEM_RST_REG;
      end
      miss_ff <= {`SLEM_TOP_W{1'b0}};
    end else begin
      for (rp = 0; rp < `SLEM_NPER; rp = rp + 1) begin
        flag_ff[rp] <= nxt_flag[rp];
        mask_ff[rp] <= nxt_mask[rp];
      end
      miss_ff <= nxt_miss;
    end
  end

  // Write handshake sequencing
  always @(posedge i_clock) begin
    if (i_rst) begin
      wstate_ff <= WS_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= {`SLEM_ADDR_W{1'b0}};
      wdata_ff  <= 32'h00000000;
      wstrb_ff  <= 4'h0;
      bresp_ff  <= `SLEM_RESP_OKAY;
    end else begin
      case (wstate_ff)
        WS_IDLE: begin
          if (aw_take) begin
            awaddr_ff <= i_awaddr;
          end
          if (w_take) begin
            wdata_ff <= i_wdata;
            wstrb_ff <= i_wstrb;
          end
          if (wr_fire) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            bresp_ff  <= wr_map_ok ? `SLEM_RESP_OKAY : `SLEM_RESP_SLVERR;
            wstate_ff <= WS_RESP;
          end else begin
            aw_got_ff <= aw_got_ff | aw_take;
            w_got_ff  <= w_got_ff | w_take;
          end
        end
        WS_RESP: begin
          if (i_bready) begin
            wstate_ff <= WS_IDLE;
          end
        end
        default: begin
          wstate_ff <= WS_IDLE;
        end
      endcase
    end
  end

  // Read decode
  always @* begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    case (rd_region)
      RG_FLAG: begin
        rd_val = flag_ff[rd_idx];
      end
      RG_MASK: begin
        rd_val = mask_ff[rd_idx];
      end
      RG_MISS: begin
        rd_val = {{(32-`SLEM_TOP_W){1'b0}}, miss_ff};
      end
      RG_TOP: begin
        rd_val = {{(32-`SLEM_TOP_W){1'b0}}, top_req};
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  assign o_arready = ~rvalid_ff;
  assign o_rvalid  = rvalid_ff;
  assign o_rdata   = rdata_ff;
  assign o_rresp   = rresp_ff;

  always @(posedge i_clock) begin
    if (i_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `SLEM_RESP_OKAY;
    end else if (rvalid_ff) begin
      if (i_rready) begin
        rvalid_ff <= 1'b0;
      end
    end else if (i_arvalid) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_val;
      rresp_ff  <= rd_ok ? `SLEM_RESP_OKAY : `SLEM_RESP_SLVERR;
    end
  end

endmodule

// file: tb.sv
/* Self-checking bench for the second-level event aggregator.
   Assumes the design, the event model and the checker are compiled first. */
`timescale 1ns/1ns
module tb;
  logic i_clock = 1'b0, i_rst = 1'b1, go = 1'b0;
  logic [7:0] idx = 8'h0, i_awaddr = 8'h0, i_araddr = 8'h0;
  logic [255:0] pulse;
  logic i_debug_request = 1'b0, i_mac_receive_top_request = 1'b0, i_mac_transmit_top_request = 1'b0;
  logic i_security_top_request = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [3:0] i_ext_pin_request = 4'h0, i_wstrb = 4'hf, strb = 4'hf;
  logic [2:0] i_awprot = 3'h0, i_arprot = 3'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata, rdat;
  logic [1:0] o_bresp, o_rresp, resp;
  logic [19:0] o_top_request;
  int n_tests = 0, n_mismatch = 0, p, k;
  int pos[8] = '{0, 1, 5, 6, 11, 17, 18, 19};
  always #20 i_clock = ~i_clock;
  slem_evsrc u_src (.i_clock, .i_go(go), .i_idx(idx), .o_pulse(pulse));
  slem_second_level_aggregator dut (.i_clock, .i_rst, .i_event_pulse(pulse), .i_debug_request,
    .i_ext_pin_request, .i_mac_receive_top_request, .i_mac_transmit_top_request, .i_security_top_request,
    .o_top_request, .i_awvalid, .o_awready, .i_awaddr, .i_awprot, .i_wvalid, .o_wready, .i_wdata,
    .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .i_arprot,
    .o_rvalid, .i_rready, .o_rdata, .o_rresp);
  task results;
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Event on index i for n consecutive cycles
  task ev(input [7:0] i, input int n);
    @(posedge i_clock);
    go <= 1'b1;
    idx <= i;
    repeat (n) @(posedge i_clock);
    go <= 1'b0;
    repeat (2) @(posedge i_clock);
  endtask
  // Write; e >= 0 lands an event on the commit edge
  task wr(input [7:0] a, input [31:0] d, input int e = -1);
    @(posedge i_clock);
    if (e >= 0) begin
      go <= 1'b1;
      idx <= e[7:0];
      @(posedge i_clock);
      go <= 1'b0;
    end
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= strb;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clock);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) break;
    end
    i_bready <= 1'b0;
    resp = o_bresp;
    if (k == 20) begin
      n_mismatch++;
      results;
    end
  endtask
  task rd(input [7:0] a);
    @(posedge i_clock);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clock);
      if (o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) break;
    end
    i_rready <= 1'b0;
    rdat = o_rdata;
    resp = o_rresp;
    if (k == 20) begin
      n_mismatch++;
      results;
    end
  endtask
  initial begin
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(8'h80);
    chk("miss_rst", rdat, 32'h0);
    chk("top_rst", o_top_request, 32'h0);
    $display("Test reset done");
    ev(8'd0, 1);
    rd(8'h00);
    chk("flag_set", rdat, 32'h1);
    chk("top_off", o_top_request[0], 1'b0);
    strb = 4'he;
    wr(8'h40, 32'hffffffff);
    chk("top_gated", o_top_request[0], 1'b0);
    strb = 4'hf;
    wr(8'h40, 32'h1);
    chk("top_late", o_top_request[0], 1'b1);
    ev(8'd0, 2);
    rd(8'h80);
    chk("miss_set", rdat, 32'h1);
    rd(8'h00);
    chk("no_count", rdat, 32'h1);
    wr(8'h80, 32'h0);
    rd(8'h80);
    chk("miss_w0", rdat, 32'h1);
    wr(8'h80, 32'h1);
    rd(8'h80);
    chk("miss_w1", rdat, 32'h0);
    wr(8'h00, 32'h0);
    chk("flag_w0", o_top_request[0], 1'b1);
    wr(8'h00, 32'h1, 0);
    chk("set_wins", o_top_request[0], 1'b1);
    wr(8'h80, 32'h1, 0);
    rd(8'h80);
    chk("miss_wins", rdat, 32'h1);
    wr(8'h80, 32'h1);
    wr(8'h00, 32'h1);
    chk("flag_w1", o_top_request[0], 1'b0);
    wr(8'h40, 32'h0);
    $display("Test timer done");
    for (p = 0; p < 8; p++) begin
      ev(8'(32 * p + 31), 1);
      ev(8'(32 * p), 2);
      rd(8'(4 * p));
      chk("flag_bits", rdat, 32'h1);
      wr(8'(64 + 4 * p), 32'h1);
      chk("top_or", o_top_request, 32'h1 << pos[p]);
      ev(8'(32 * p), 1);
      rd(8'h80);
      chk("miss_bit", rdat, 32'h1 << pos[p]);
      wr(8'h80, 32'hffffffff);
      wr(8'(4 * p), 32'h1);
      wr(8'(64 + 4 * p), 32'h0);
      chk("mask_off", o_top_request, 32'h0);
    end
    $display("Test peripherals done");
    i_debug_request <= 1'b1;
    i_ext_pin_request <= 4'ha;
    i_mac_receive_top_request <= 1'b1;
    i_mac_transmit_top_request <= 1'b1;
    i_security_top_request <= 1'b1;
    @(posedge i_clock);
    chk("direct", o_top_request, 32'h1a680);
    wr(8'h88, 32'h1);
    chk("bad_addr", resp, 32'h2);
    rd(8'h84);
    chk("top_stat", rdat, 32'h1a680);
    chk("top_resp", resp, 32'h0);
    rd(8'h88);
    chk("bad_read", resp, 32'h2);
    chk("bad_data", rdat, 32'h0);
    wr(8'h41, 32'h1);
    chk("bad_align", resp, 32'h2);
    rd(8'h40);
    chk("align_keep", rdat, 32'h0);
    $display("Test direct done");
    results;
  end
endmodule
